// ===== design/core_alu.sv
// Combinational 8-bit ALU with zero and carry results.
// Assumes the caller decides which flags are kept.
`timescale 1ns/10ps
`default_nettype none
module core_alu
import core_pkg::*;
(
	input  wire alu_op_t       i_op,
	input  wire logic    [7:0] i_a,
	input  wire logic    [7:0] i_b,
	input  wire logic          i_carry,
	output alu_out_t           o_out
);
	logic [8:0] wide;  // Result with carry in bit 8

	// Operation select; carry is borrow for subtract and compare
	always_comb
	begin
		wide = 9'h000;
		unique case (i_op)
			alu_add: wide = {1'b0, i_a} + {1'b0, i_b};
			alu_and: wide = {1'b0, i_a & i_b};
			alu_cmp: wide = {1'b0, i_a} - {1'b0, i_b};
			alu_sub: wide = {1'b0, i_a} - {1'b0, i_b};
			alu_inc: wide = {i_carry, i_a + 8'h01};
			alu_dec: wide = {i_carry, i_a - 8'h01};
			alu_clr: wide = 9'h000;
			alu_com: wide = {i_a[7], ~i_a};
			alu_rlc: wide = {i_a, i_carry};
			alu_sla: wide = {i_a, 1'b0};
		endcase
		o_out.result = wide[7:0];
		o_out.zero   = (wide[7:0] == 8'h00);
		o_out.carry  = wide[8];
	end
endmodule
`default_nettype wire

// ===== design/core_exec.sv
// Instruction fetch, decode and execution of the 8-bit core.
// Assumes program memory answers combinationally on o_prog_addr.
//
// What this block does
// - Add/and/compare/subtract use accumulator and operand
// - Clear/decrement/increment reach any data byte
// - Complement/rotate/shift work on accumulator
// - Arithmetic ops: four cycles; inc/dec keep carry, memory clear keeps both flags
// - Flag branches: one byte, two cycles
// - Flag branch span -15 to +16
// - Bit branches: three bytes, five cycles
// - Bit branch displacement -126 to +129
// - Tested bit copied into carry
// - Three-bit field selects the bit
// - Bit set/clear: two bytes, four cycles
// - Watchdog selected turns stop into wait
// - Jump/call: twelve-bit target, four cycles
`timescale 1ns/10ps
`default_nettype none
module core_exec
import core_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_reset_n,
	input  wire logic [7:0]  i_prog_data,
	input  wire logic        i_watchdog_select,
	input  wire logic        i_wake,
	output logic      [11:0] o_prog_addr,
	output logic      [7:0]  o_accumulator,
	output logic             o_zero_flag,
	output logic             o_carry_flag,
	output logic             o_halted,
	output logic             o_stopped,
	output logic             o_instr_done
);
	// Pin synchronisers
	logic wdg_meta_reg;   // First stage, read only by second
	logic wdg_sync_reg;   // Watchdog option, synchronised
	logic wake_meta_reg;
	logic wake_sync_reg;  // Wake request, synchronised

	// Core state
	run_state_t   state_reg, state_next;
	logic [11:0]  pc_reg, pc_next;           // Current instruction
	logic [11:0]  addr_reg, addr_next;       // Program fetch address
	logic [2:0]   cnt_reg, cnt_next;         // Cycle within instruction
	logic [7:0]   opcode_reg, opcode_next;
	logic [7:0]   byte2_reg, byte2_next;
	logic [7:0]   byte3_reg, byte3_next;
	logic [7:0]   acc_reg, acc_next;
	logic         zero_reg, zero_next;
	logic         carry_reg, carry_next;
	logic [7:0]   daddr_reg, daddr_next;     // Data operand address
	logic         stop_reg, stop_next;
	logic         done_reg, done_next;
	stack_entry_t stack_reg [STACK_DEPTH];   // Top is index 0
	stack_entry_t stack_next [STACK_DEPTH];

	// Datapath wires
	decode_t     dec;
	alu_out_t    alu_out;
	logic [7:0]  alu_a;
	logic [7:0]  alu_b;
	logic [7:0]  ram_q;
	logic [7:0]  ram_rd_addr;
	logic        ram_we;
	logic [7:0]  ram_wr_data;
	logic        exec;        // Last cycle of the instruction
	logic        indirect;
	logic        ram_dest;    // Result goes back to data space
	logic [2:0]  bit_num;
	logic        tested_bit;
	logic        cond_met;
	logic [11:0] pc_plus_len;
	logic [11:0] rel_target;
	logic [11:0] bit_target;
	logic [11:0] long_target;

	// Two flops on the watchdog and wake pins before any logic looks at them
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			wdg_meta_reg  <= 1'b0;
			wdg_sync_reg  <= 1'b0;
			wake_meta_reg <= 1'b0;
			wake_sync_reg <= 1'b0;
		end
		else
		begin
			wdg_meta_reg  <= i_watchdog_select;
			wdg_sync_reg  <= wdg_meta_reg;
			wake_meta_reg <= i_wake;
			wake_sync_reg <= wake_meta_reg;
		end
	end

	// Decode from the latched opcode; valid from the second cycle on
	always_comb
	begin
		dec.kind   = kind_control;
		dec.alu    = alu_add;
		dec.mode   = mode_t'({opcode_reg[F_MODE_HI], opcode_reg[F_MODE_LO]});
		dec.ctrl   = ctrl_nop;
		dec.bytes  = LEN_ONE;
		dec.cycles = CYC_SHORT;
		if (!opcode_reg[0])
		begin
			dec.kind = kind_rel;
		end
		else if (opcode_reg[2:0] == 3'b001)
		begin
			dec.kind   = opcode_reg[F_DIR] ? kind_jump : kind_call;
			dec.bytes  = LEN_TWO;
			dec.cycles = CYC_LONG;
		end
		else if (opcode_reg[2:0] == 3'b011)
		begin
			if (!opcode_reg[F_DIR])
			begin
				dec.kind   = kind_bit_branch;
				dec.bytes  = LEN_THREE;
				dec.cycles = CYC_BIT_TEST;
			end
			else
			begin
				dec.kind   = kind_bit_write;
				dec.bytes  = LEN_TWO;
				dec.cycles = CYC_LONG;
			end
		end
		else
		begin
			dec.kind   = kind_alu;
			dec.cycles = CYC_LONG;
			dec.bytes  = (dec.mode == mode_imm || dec.mode == mode_dir)
				? LEN_TWO : LEN_ONE;
			unique case (opcode_reg[F_GROUP_LO +: 4])
				grp_add:  dec.alu = alu_add;
				grp_and:  dec.alu = alu_and;
				grp_cmp:  dec.alu = alu_cmp;
				grp_sub:  dec.alu = alu_sub;
				grp_inc:  dec.alu = alu_inc;
				grp_dec:  dec.alu = alu_dec;
				grp_clr:
				begin
					dec.alu = alu_clr;
					// Direct clear carries a spare third byte
					if (dec.mode == mode_dir)
						dec.bytes = LEN_THREE;
				end
				grp_acc:
				begin
					// Accumulator-only group; no data operand
					unique case (dec.mode)
						mode_ind_y: dec.alu = alu_com;
						mode_ind_x: dec.alu = alu_rlc;
						default:    dec.alu = alu_sla;
					endcase
					dec.bytes = (dec.mode == mode_ind_y ||
						dec.mode == mode_ind_x) ? LEN_ONE : LEN_TWO;
				end
				grp_stop:
				begin
					dec.kind   = kind_control;
					dec.ctrl   = ctrl_stop;
					dec.bytes  = LEN_ONE;
					dec.cycles = CYC_SHORT;
				end
				default:
				begin
					// Control group; unused codes behave as no-op
					dec.kind   = kind_control;
					dec.bytes  = LEN_ONE;
					dec.cycles = CYC_SHORT;
					if (opcode_reg[F_GROUP_LO +: 4] == grp_ctrl)
					begin
						unique case (dec.mode)
							mode_ind_y: dec.ctrl = ctrl_nop;
							mode_ind_x: dec.ctrl = ctrl_ret;
							mode_imm:   dec.ctrl = ctrl_return_from_interrupt;
							mode_dir:   dec.ctrl = ctrl_wait;
						endcase
					end
				end
			endcase
		end
	end

	// Operand routing and branch arithmetic
	always_comb
	begin
		exec     = (state_reg == st_run) &&
			(cnt_reg == dec.cycles - CYC_ONE);
		// Only the arithmetic group has pointer modes; bit branches share
		// the mode bits and must read their byte directly
		indirect = (dec.kind == kind_alu) &&
			((dec.mode == mode_ind_x) || (dec.mode == mode_ind_y));
		ram_dest = (dec.kind == kind_alu) && (dec.mode != mode_imm) &&
			(dec.alu == alu_inc || dec.alu == alu_dec ||
			dec.alu == alu_clr);
		alu_a = ((dec.alu == alu_inc || dec.alu == alu_dec) && ram_dest)
			? ram_q : acc_reg;
		alu_b = (dec.mode == mode_imm) ? byte2_reg : ram_q;
		bit_num    = opcode_reg[F_BITNUM_LO +: 3];
		tested_bit = ram_q[bit_num];
		unique case (cond_t'(opcode_reg[F_COND_LO +: 2]))
			cond_nonzero:  cond_met = !zero_reg;
			cond_no_carry: cond_met = !carry_reg;
			cond_zero:     cond_met = zero_reg;
			cond_carry:    cond_met = carry_reg;
		endcase
		pc_plus_len = pc_reg + {10'h000, dec.bytes};
		// Forward reaches +1..+16, backward 0..-15
		if (opcode_reg[F_DIR])
			rel_target = pc_reg -
				{8'h00, opcode_reg[F_SPAN_LO +: 4]};
		else
			rel_target = pc_reg +
				{8'h00, opcode_reg[F_SPAN_LO +: 4]} + 12'h001;
		// Signed byte around the address after the first two bytes
		bit_target  = pc_reg + 12'h002 +
			{{4{byte3_reg[7]}}, byte3_reg};
		long_target = {opcode_reg[F_GROUP_LO +: 4], byte2_reg};
		// Pointer first, then the byte it points at
		if (cnt_reg == 3'h1)
			ram_rd_addr = indirect ? ((dec.mode == mode_ind_x)
				? PTR_X_ADDR : PTR_Y_ADDR) : i_prog_data;
		else if (cnt_reg == 3'h2)
			ram_rd_addr = indirect ? ram_q : byte2_reg;
		else
			ram_rd_addr = daddr_reg;
	end

	core_alu u_alu
	(
		.i_op    (dec.alu),
		.i_a     (alu_a),
		.i_b     (alu_b),
		.i_carry (carry_reg),
		.o_out   (alu_out)
	);

	data_space_ram u_ram
	(
		.i_clock      (i_clock),
		.i_reset_n    (i_reset_n),
		.i_write      (ram_we),
		.i_write_addr (daddr_reg),
		.i_write_data (ram_wr_data),
		.i_read_addr  (ram_rd_addr),
		.o_read_data  (ram_q)
	);

	// Next state of the sequencer, registers and return stack
	always_comb
	begin
		state_next  = state_reg;
		pc_next     = pc_reg;
		cnt_next    = cnt_reg + CYC_ONE;
		opcode_next = opcode_reg;
		byte2_next  = byte2_reg;
		byte3_next  = byte3_reg;
		acc_next    = acc_reg;
		zero_next   = zero_reg;
		carry_next  = carry_reg;
		daddr_next  = daddr_reg;
		stop_next   = stop_reg;
		done_next   = exec;
		ram_we      = 1'b0;
		ram_wr_data = alu_out.result;
		for (int i = 0; i < STACK_DEPTH; i++)
			stack_next[i] = stack_reg[i];
		// Capture the fetched bytes
		if (state_reg == st_run)
		begin
			if (cnt_reg == 3'h0)
				opcode_next = i_prog_data;
			if (cnt_reg == 3'h1)
				byte2_next = i_prog_data;
			if (cnt_reg == 3'h2)
			begin
				byte3_next = i_prog_data;
				daddr_next = ram_rd_addr;
			end
		end
		if (exec)
		begin
			cnt_next = 3'h0;
			pc_next  = pc_plus_len;
			unique case (dec.kind)
				kind_rel:
				begin
					if (cond_met)
						pc_next = rel_target;
				end
				kind_jump: pc_next = long_target;
				kind_call:
				begin
					// Oldest entry drops off when the stack is full
					for (int i = STACK_DEPTH - 1; i > 0; i--)
						stack_next[i] = stack_reg[i - 1];
					stack_next[0] = '{pc_plus_len, zero_reg, carry_reg};
					pc_next = long_target;
				end
				kind_bit_branch:
				begin
					carry_next = tested_bit;
					if (tested_bit == opcode_reg[F_BITVAL])
						pc_next = bit_target;
				end
				kind_bit_write:
				begin
					ram_we      = 1'b1;
					ram_wr_data = ram_q;
					ram_wr_data[bit_num] = opcode_reg[F_BITVAL];
				end
				kind_alu:
				begin
					if (ram_dest)
						ram_we = 1'b1;
					else if (dec.alu != alu_cmp)
						acc_next = alu_out.result;
					if (!(ram_dest && dec.alu == alu_clr))
						zero_next = alu_out.zero;
					if (!ram_dest || dec.alu == alu_add)
						carry_next = alu_out.carry;
					if (dec.alu == alu_inc || dec.alu == alu_dec)
						carry_next = carry_reg;
				end
				kind_control:
				begin
					unique case (dec.ctrl)
						ctrl_ret, ctrl_return_from_interrupt:
						begin
							for (int i = 0; i < STACK_DEPTH - 1; i++)
								stack_next[i] = stack_reg[i + 1];
							stack_next[STACK_DEPTH - 1] = '0;
							pc_next = stack_reg[0].ret_pc;
							if (dec.ctrl == ctrl_return_from_interrupt)
							begin
								zero_next  = stack_reg[0].zero;
								carry_next = stack_reg[0].carry;
							end
						end
						ctrl_wait, ctrl_stop:
						begin
							state_next = st_halt;
							// Watchdog forces wait in place of stop
							stop_next  = (dec.ctrl == ctrl_stop) &&
								!wdg_sync_reg;
						end
						default: pc_next = pc_plus_len;
					endcase
				end
				default: pc_next = pc_plus_len;
			endcase
		end
		// Halted: hold until wake, then fetch the next instruction
		if (state_reg == st_halt)
		begin
			cnt_next = 3'h0;
			if (wake_sync_reg)
			begin
				state_next = st_run;
				stop_next  = 1'b0;
			end
		end
		addr_next = (exec || state_reg == st_halt)
			? pc_next : pc_reg + {9'h000, cnt_next};
	end

	// State registers
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_reg  <= st_run;
			pc_reg     <= RESET_PC;
			addr_reg   <= RESET_PC;
			cnt_reg    <= 3'h0;
			opcode_reg <= 8'h00;
			byte2_reg  <= 8'h00;
			byte3_reg  <= 8'h00;
			acc_reg    <= ACC_RESET;
			zero_reg   <= 1'b0;
			carry_reg  <= 1'b0;
			daddr_reg  <= 8'h00;
			stop_reg   <= 1'b0;
			done_reg   <= 1'b0;
			for (int i = 0; i < STACK_DEPTH; i++)
				stack_reg[i] <= '0;
		end
		else
		begin
			state_reg  <= state_next;
			pc_reg     <= pc_next;
			addr_reg   <= addr_next;
			cnt_reg    <= cnt_next;
			opcode_reg <= opcode_next;
			byte2_reg  <= byte2_next;
			byte3_reg  <= byte3_next;
			acc_reg    <= acc_next;
			zero_reg   <= zero_next;
			carry_reg  <= carry_next;
			daddr_reg  <= daddr_next;
			stop_reg   <= stop_next;
			done_reg   <= done_next;
			for (int i = 0; i < STACK_DEPTH; i++)
				stack_reg[i] <= stack_next[i];
		end
	end

	assign o_prog_addr   = addr_reg;
	assign o_accumulator = acc_reg;
	assign o_zero_flag   = zero_reg;
	assign o_carry_flag  = carry_reg;
	assign o_halted      = (state_reg == st_halt);
	assign o_stopped     = stop_reg;
	assign o_instr_done  = done_reg;
endmodule
`default_nettype wire

// ===== design/core_pkg.sv
// Shared types and constants of the 8-bit execution core.
// Assumes one core clock; opcode fields follow the decode in core_exec.
package core_pkg;

	// Reset values
	localparam logic [11:0] RESET_PC  = 12'h000;
	localparam logic [7:0]  ACC_RESET = 8'h00;

	// Indirect pointer locations in data space
	localparam logic [7:0] PTR_X_ADDR = 8'h80;
	localparam logic [7:0] PTR_Y_ADDR = 8'h81;

	// Return stack depth in entries
	localparam int STACK_DEPTH = 6;

	// Instruction cycle counts
	localparam logic [2:0] CYC_ONE      = 3'h1;
	localparam logic [2:0] CYC_SHORT    = 3'h2;
	localparam logic [2:0] CYC_LONG     = 3'h4;
	localparam logic [2:0] CYC_BIT_TEST = 3'h5;

	// Instruction lengths in bytes
	localparam logic [1:0] LEN_ONE   = 2'h1;
	localparam logic [1:0] LEN_TWO   = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;

	// Opcode field positions
	localparam int F_GROUP_LO  = 4;  // Group / span / jump high bits
	localparam int F_SPAN_LO   = 4;  // Relative span, 4 bits
	localparam int F_DIR       = 3;  // Relative direction, 1 = back
	localparam int F_COND_LO   = 1;  // Flag condition, 2 bits
	localparam int F_BITNUM_LO = 5;  // Bit number, 3 bits
	localparam int F_BITVAL    = 4;  // Bit value tested or written
	localparam int F_MODE_HI   = 3;  // Addressing mode high bit
	localparam int F_MODE_LO   = 1;  // Addressing mode low bit

	// Instruction families
	typedef enum logic [2:0] {
		kind_rel, kind_jump, kind_call, kind_bit_branch,
		kind_bit_write, kind_alu, kind_control
	} kind_t;

	// Arithmetic group selected by the opcode high nibble
	typedef enum logic [3:0] {
		grp_add, grp_and, grp_cmp, grp_sub, grp_inc, grp_dec,
		grp_clr, grp_acc, grp_ctrl, grp_stop
	} group_t;

	typedef enum logic [3:0] {
		alu_add, alu_and, alu_cmp, alu_sub, alu_inc, alu_dec,
		alu_clr, alu_com, alu_rlc, alu_sla
	} alu_op_t;

	// Addressing mode from opcode bits 3 and 1
	typedef enum logic [1:0] {
		mode_ind_y, mode_ind_x, mode_imm, mode_dir
	} mode_t;

	// Flag condition from opcode bits 2:1
	typedef enum logic [1:0] {
		cond_nonzero, cond_no_carry, cond_zero, cond_carry
	} cond_t;

	typedef enum logic [2:0] {
		ctrl_nop, ctrl_ret, ctrl_return_from_interrupt, ctrl_wait, ctrl_stop
	} ctrl_t;

	typedef enum logic {
		st_run, st_halt
	} run_state_t;

	// Decoded instruction
	typedef struct packed {
		kind_t      kind;
		alu_op_t    alu;
		mode_t      mode;
		ctrl_t      ctrl;
		logic [1:0] bytes;
		logic [2:0] cycles;
	} decode_t;

	// ALU result with flags
	typedef struct packed {
		logic [7:0] result;
		logic       zero;
		logic       carry;
	} alu_out_t;

	// Return stack entry: address plus flags for interrupt return
	typedef struct packed {
		logic [11:0] ret_pc;
		logic        zero;
		logic        carry;
	} stack_entry_t;

endpackage

// ===== design/data_space_ram.sv
// 256-byte data space with registered read data.
// Assumes write and read addresses come from the core clock domain.
`timescale 1ns/10ps
`default_nettype none
module data_space_ram
(
	input  wire logic       i_clock,
	input  wire logic       i_reset_n,
	input  wire logic       i_write,
	input  wire logic [7:0] i_write_addr,
	input  wire logic [7:0] i_write_data,
	input  wire logic [7:0] i_read_addr,
	output logic      [7:0] o_read_data
);
	logic [7:0] mem [256];  // Storage array, no reset
	logic [7:0] read_reg;   // Read data register
	logic [7:0] read_next;

	// Read is ahead of a same-cycle write: old data wins
	always_comb
	begin
		read_next = mem[i_read_addr];
	end

	// Array write, kept out of reset so it maps onto RAM
	always_ff @(posedge i_clock)
	begin
		if (i_write)
		begin
			mem[i_write_addr] <= i_write_data;
		end
	end

	// Read register
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			read_reg <= 8'h00;
		end
		else
		begin
			read_reg <= read_next;
		end
	end

	assign o_read_data = read_reg;
endmodule
`default_nettype wire

// ===== sim/core_exec_checker.sv
// Port-level checker for core_exec: lengths, targets and flags.
// Assumes it is bound to core_exec and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module core_exec_checker
(
	input wire logic        i_clock,
	input wire logic        i_reset_n,
	input wire logic [7:0]  i_prog_data,
	input wire logic        i_watchdog_select,
	input wire logic        i_wake,
	input wire logic [11:0] o_prog_addr,
	input wire logic [7:0]  o_accumulator,
	input wire logic        o_zero_flag,
	input wire logic        o_carry_flag,
	input wire logic        o_halted,
	input wire logic        o_stopped,
	input wire logic        o_instr_done
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	logic        start;   // First cycle of an instruction while running
	logic        hit;     // Flag branch condition met
	logic [11:0] rel_tgt; // Where a flag branch must go next
	assign start = o_instr_done && !o_halted;
	// Branch decision and target from the opcode on the fetch bus
	always_comb
	begin
		case (i_prog_data[2:1])
			2'h0:    hit = !o_zero_flag;
			2'h1:    hit = !o_carry_flag;
			2'h2:    hit = o_zero_flag;
			default: hit = o_carry_flag;
		endcase
		if (!hit)
			rel_tgt = o_prog_addr + 12'h001;
		else if (i_prog_data[3])
			rel_tgt = o_prog_addr - i_prog_data[7:4];
		else
			rel_tgt = o_prog_addr + i_prog_data[7:4] + 12'h001;
	end
	flag_branch_time_a: assert property (start && !i_prog_data[0]
		|-> ##2 o_instr_done) else $error("flag branch length wrong");
	flag_branch_flags_a: assert property (start && !i_prog_data[0]
		|-> ##2 (o_zero_flag == $past(o_zero_flag, 2)
		&& o_carry_flag == $past(o_carry_flag, 2)))
		else $error("flag branch changed flags");
	branch_target_a: assert property (start && !i_prog_data[0]
		|-> ##2 o_prog_addr == $past(rel_tgt, 2))
		else $error("flag branch target wrong");
	jump_target_a: assert property (start && i_prog_data[2:0] == 3'h1
		|-> ##4 (o_instr_done && o_prog_addr ==
		{$past(i_prog_data[7:4], 4), $past(i_prog_data, 3)}))
		else $error("jump or call target or length wrong");
	bit_branch_time_a: assert property (start
		&& i_prog_data[3:0] == 4'h3 |-> ##5 (o_instr_done
		&& o_zero_flag == $past(o_zero_flag, 5)))
		else $error("bit branch length wrong");
	bit_write_flags_a: assert property (start
		&& i_prog_data[3:0] == 4'hB |-> ##4 (o_instr_done
		&& o_zero_flag == $past(o_zero_flag, 4)
		&& o_carry_flag == $past(o_carry_flag, 4)))
		else $error("bit write length or flags wrong");
	add_result_a: assert property (start && i_prog_data == 8'h0D
		|-> ##4 ({o_carry_flag, o_accumulator} ==
		{1'b0, $past(o_accumulator, 4)} + {1'b0, $past(i_prog_data, 3)}
		&& o_zero_flag == (o_accumulator == 8'h00)))
		else $error("add immediate result wrong");
	compare_keeps_a: assert property (start && i_prog_data == 8'h2D
		|-> ##4 (o_accumulator == $past(o_accumulator, 4) && o_zero_flag
		== ($past(o_accumulator, 4) == $past(i_prog_data, 3))))
		else $error("compare changed accumulator");
	inc_carry_a: assert property (start && i_prog_data == 8'h4D
		|-> ##4 (o_accumulator == $past(o_accumulator, 4) + 8'h01
		&& o_carry_flag == $past(o_carry_flag, 4)))
		else $error("increment result or carry wrong");
	stop_swap_a: assert property ($rose(o_halted)
		&& i_watchdog_select && $past(i_watchdog_select, 3) |-> !o_stopped)
		else $error("stop taken with watchdog selected");
	cover property (start && !i_prog_data[0] && hit);
	cover property (start && i_prog_data[3:0] == 4'h3);
	cover property ($rose(o_stopped));
endmodule
bind core_exec core_exec_checker u_core_exec_checker (.i_clock,
	.i_reset_n, .i_prog_data, .i_watchdog_select, .i_wake, .o_prog_addr,
	.o_accumulator, .o_zero_flag, .o_carry_flag, .o_halted, .o_stopped,
	.o_instr_done);
`default_nettype wire

// ===== sim/core_instruction_execution_test.sv
// Self-checking bench for core_exec with a program memory model.
// Assumes the checker is bound in; each scenario reloads and resets.
`timescale 1ns/10ps
`default_nettype none
module core_instruction_execution_test;
	import core_pkg::*;
	logic        clock, reset_n, watchdog_select, wake;
	logic [7:0]  prog_data, acc, op, b, disp, ra;
	logic [11:0] prog_addr, tgt;
	logic        zero, carry, halted, stopped, done;
	logic        acc_z, acc_c, v, t, y, cf, hit;
	logic [7:0]  acc_m;          // Model accumulator
	logic [2:0]  bn;             // Bit number under test
	logic [11:0] trace [$];      // Start address of each instruction after the first
	logic [7:0]  ops [10] = '{8'h0D, 8'h1D, 8'h2D, 8'h3D, 8'h4D,
		8'h5D, 8'h6D, 8'h75, 8'h77, 8'h7D};
	int          failures, checked, r, j, a;
	core_exec u_core_exec (.i_clock(clock), .i_reset_n(reset_n),
		.i_prog_data(prog_data), .i_watchdog_select(watchdog_select),
		.i_wake(wake), .o_prog_addr(prog_addr), .o_accumulator(acc),
		.o_zero_flag(zero), .o_carry_flag(carry), .o_halted(halted),
		.o_stopped(stopped), .o_instr_done(done));
	prog_rom u_prog_rom (.i_addr(prog_addr), .o_data(prog_data));
	// Free-running 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Done marks the first cycle of the next instruction; sampled
	// mid-cycle so the launching edge never races the read
	always @(negedge clock)
		if (done === 1'b1)
			trace.push_back(prog_addr);
	task automatic check(string what, logic [15:0] seen, logic [15:0] want);
		checked++;
		if (seen !== want)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic close_out();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Bounded wait on the halt level; a hang ends the run
	task automatic wait_for(logic want);
		int k;
		k = 0;
		while (halted !== want && k < 3000)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		if (k == 3000)
		begin
			failures++;
			close_out();
		end
	endtask
	// Fill with halts so a stray fetch stops the core at once
	task automatic fill();
		for (int i = 0; i < 4096; i++)
			u_prog_rom.mem[i] = 8'h8F;
	endtask
	task automatic load(int at, int n, logic [63:0] v);
		for (int i = 0; i < n; i++)
			u_prog_rom.mem[at + i] = v[8 * (n - 1 - i) +: 8];
	endtask
	task automatic restart();
		trace.delete();
		@(posedge clock);
		#1 reset_n = 1'b0;
		repeat (6) @(posedge clock);
		#1 reset_n = 1'b1;
		wait_for(1'b1);
	endtask
	function automatic logic [11:0] next_after(logic [11:0] at);
		for (int i = 0; i + 1 < trace.size(); i++)
			if (trace[i] === at)
				return trace[i + 1];
		return 12'hFFF;
	endfunction
	// Reference for the accumulator group; bit 8 is the new carry
	function automatic void model(logic [7:0] o, logic [7:0] d);
		logic [8:0] s;
		case (o)
			8'h0D:        s = {1'b0, acc_m} + {1'b0, d};
			8'h1D:        s = {1'b0, acc_m & d};
			8'h2D, 8'h3D: s = {1'b0, acc_m} - {1'b0, d};
			8'h4D:        s = {acc_c, acc_m + 8'h01};
			8'h5D:        s = {acc_c, acc_m - 8'h01};
			8'h6D:        s = 9'h000;
			8'h75:        s = {acc_m[7], ~acc_m};
			8'h77:        s = {acc_m, acc_c};
			default:      s = {acc_m, 1'b0};
		endcase
		acc_z = (s[7:0] == 8'h00);
		acc_c = s[8];
		if (o != 8'h2D)
			acc_m = s[7:0];
	endfunction
	initial
	begin
		reset_n = 1'b0;
		watchdog_select = 1'b0;
		wake = 1'b0;
		failures = 0;
		checked = 0;
		void'($urandom(32'h898741C3));
		// Random accumulator chains; operand often equals acc for zeros
		for (r = 0; r < 25; r++)
		begin
			fill();
			load(0, 2, 16'h6D00);
			{acc_m, acc_z, acc_c} = 10'h002;
			a = 2;
			for (j = 0; j < 8; j++)
			begin
				op = ops[$urandom_range(0, 9)];
				b = ($urandom_range(0, 3) == 0) ? acc_m : 8'($urandom);
				if (op == 8'h75 || op == 8'h77)
					load(a, 1, op);
				else
					load(a, 2, {op, b});
				a += (op == 8'h75 || op == 8'h77) ? 1 : 2;
				model(op, b);
			end
			restart();
			check("accumulator", acc, acc_m);
			check("flags", {zero, carry}, {acc_z, acc_c});
		end
		// Flag branches in every condition, both directions
		for (r = 0; r < 24; r++)
		begin
			fill();
			cf = r[0];
			y = 1'($urandom);
			load(0, 8, {16'h6D00, 8'h0D, cf ? 8'hFF : 8'h00, 8'h0D,
				7'h00, y, 16'h0920} + (cf ? 64'h010000 : 64'h0));
			op = {(r < 8) ? 4'hF : 4'($urandom), 1'($urandom),
				r[2:1], 1'b0};
			// A taken backward span of zero would spin on itself
			if (op[7:3] == 5'h01)
				op[3] = 1'b0;
			load(12'h020, 1, op);
			hit = (r[2:1] == 0) ? y : (r[2:1] == 1) ? !cf :
				(r[2:1] == 2) ? !y : cf;
			tgt = !hit ? 12'h021 : op[3] ? 12'h020 - op[7:4] :
				12'h021 + op[7:4];
			restart();
			check("branch", next_after(12'h020), tgt);
			check("branch flags", {zero, carry}, {!y, cf});
		end
		// Bit write then bit test branch over the written byte
		for (r = 0; r < 16; r++)
		begin
			fill();
			bn = 3'($urandom);
			v = 1'($urandom);
			t = r[0];
			ra = 8'($urandom);
			disp = (r == 2) ? 8'h80 : (r == 3) ? 8'h7F : 8'($urandom);
			tgt = 12'h088 + {{4{disp[7]}}, disp};
			while (tgt >= 12'h080 && tgt <= 12'h088)
			begin
				disp = 8'($urandom);
				tgt = 12'h088 + {{4{disp[7]}}, disp};
			end
			load(0, 2, 16'h0980);
			load(12'h080, 6, {16'h6D00, bn, v, 4'hB, ra,
				bn ^ 3'h1, ~v, 4'hB, ra});
			load(12'h086, 3, {bn, t, 4'h3, ra, disp});
			restart();
			check("bit branch", next_after(12'h086),
				(v == t) ? tgt : 12'h089);
			check("bit carry", {zero, carry}, {1'b1, v});
		end
		// Memory inc/dec chains, direct and through X, carry left set;
		// then a direct clear of a nonzero byte must keep both flags
		for (r = 0; r < 8; r++)
		begin
			fill();
			load(0, 8, 64'h6F01004F016F8000);
			load(8, 5, 40'h6F00003D01);
			a = 13;
			b = 8'h00;
			for (j = 0; j < 4; j++)
			begin
				op = {3'h2, 1'($urandom), 1'($urandom) ? 4'h7 : 4'hF};
				b = op[4] ? b - 8'h01 : b + 8'h01;
				if (op[3])
					load(a, 2, {op, 8'h00});
				else
					load(a, 1, op);
				a += op[3] ? 2 : 1;
			end
			load(a, 3, 24'h6F0100);
			restart();
			check("memory op", u_core_exec.u_ram.mem[0], b);
			check("direct clear", u_core_exec.u_ram.mem[1],
				8'h00);
			check("memory flags", {acc, zero, carry},
				{8'hFF, b == 8'h00, 1'b1});
		end
		// Call, return with and without flags, stop or wait, wake
		for (r = 0; r < 4; r++)
		begin
			fill();
			load(0, 7, 56'h6D0031459D0D01 - 56'h0000000008_0000);
			load(12'h345, 3, {16'h0DFF, r[0] ? 8'h8D : 8'h87});
			watchdog_select = r[1];
			restart();
			check("call", next_after(12'h002), 12'h345);
			check("return", next_after(12'h347), 12'h004);
			check("ret flags", {zero, carry}, {r[0], 1'b0});
			check("stop", {halted, stopped}, {1'b1, !r[1]});
			wake = 1'b1;
			wait_for(1'b0);
			wake = 1'b0;
			wait_for(1'b1);
			check("after wake", {acc, carry}, 9'h001);
		end
		close_out();
	end
endmodule
`default_nettype wire

// ===== sim/prog_rom.sv
// Program memory model: 4K bytes, combinational read.
// Assumes the bench fills mem before reset is released.
`timescale 1ns/10ps
`default_nettype none
module prog_rom
(
	input  wire logic [11:0] i_addr,
	output logic      [7:0]  o_data
);
	logic [7:0] mem [4096]; // Loaded by the bench per scenario
	// Answers in the same cycle, as the core expects
	assign o_data = mem[i_addr];
endmodule
`default_nettype wire
